// file: design/fcs_flash_sequencer.sv
// Purpose: command decoder and embedded-algorithm control, two flash arrays
// Assumes: MCU pins are asynchronous; array data arrives on clk
// Notes: AXI4-Lite holds sector protection and shows decoder status
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns

// What this block does
// - Every sector of both arrays has its own protect bit.
// - Erase whole sectors or whole array; program one 16-bit word.
// - Ready/busy output is 0 during program or erase, else 1.
// - Plain bus writes never change array contents.
// - In read mode a selected read returns array data directly.
// - Commands open with AAh at AAAh, 55h at 554h, then command byte.
// - Only the twelve low address bits are decoded.
// - Program address is captured on the write strobe's falling edge.
// - Program data is captured on the write strobe's rising edge.
// - Commands go to the array whose sector select is high.
// - Identify mode: 02h unselected gives identifier, 04h gives protect status.
// - Identify or protect reads hold until a F0h reset write.
// - Sector erase takes six cycles; more 30h within 80 us add sectors.
// - B0h suspends a running sector erase only.
// - 30h resumes erase only while suspended.
// - Bypass mode: A0h at any address then data word programs.
// - Bypass ends only with 90h then 00h.
// - Bad byte or inter-write time-out returns the decoder home.
// - After reset the decoder is in read mode.
// - Status bit 7 shows complement of bit written, 0 during erase.
// - Status bit 6 toggles on each read while busy.
module fcs_flash_sequencer #(
  parameter int ADD_WINDOW_CYC = fcs_pkg::ADD_WINDOW_CYC,
  parameter int ERASE_CYC = fcs_pkg::ERASE_CYC,
  parameter int CMD_TIMEOUT_CYC = fcs_pkg::CMD_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite register slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // MCU bus pins
  input wire logic [15:0] mcu_addr,
  input wire logic [15:0] mcu_wdata,
  input wire logic mcu_wr_n,
  input wire logic mcu_rd_n,
  input wire logic [15:0] primary_sector_select,
  input wire logic [3:0] secondary_sector_select,
  output logic [15:0] mcu_rdata,
  output logic ready_busy_out,
  // Array side
  input wire logic [15:0] arr_rdata,
  output fcs_pkg::fcs_arr_cmd_s arr_cmd
);
  typedef enum logic [3:0] {
    ST_READ, ST_UNL1, ST_UNL2, ST_PROG, ST_ES0, ST_ES1, ST_ES2,
    ST_EWIN, ST_BUSY, ST_SUSP, ST_ID, ST_BYP, ST_BPROG, ST_BEXIT
  } fcs_state_e;

  localparam int PIN_W = 54;
  // Strobes rest high in reset so no false edge follows its release
  localparam logic [PIN_W-1:0] PIN_IDLE = 54'h300000;
  localparam logic [fcs_pkg::CNT_W-1:0] ONE = 1;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  fcs_state_e state, home_st;
  logic [PIN_W-1:0] pin_meta, pin_sync;
  logic [15:0] s_addr, s_wdata, s_psel, cap_addr, pd, mask, sel_mask;
  logic [15:0] prot_sel, prot_cur;
  logic [3:0] s_ssel;
  logic s_wr_n, s_rd_n, wr_prev, rd_prev, wr_fall, wr_rise, rd_fall;
  logic pri_sel, any_sel, sel_bank, bank, sus, byp, is_erase, is_bulk;
  logic at_a, at_b, tog, seq_st;
  logic [7:0] cmd;
  logic [19:0] protect;
  logic [fcs_pkg::CNT_W-1:0] tmr, op_cnt;
  logic aw_got, w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Two flops on every pin; a multi-bit bus can skew by one cycle, so
  // commands are sampled only on a stable strobe edge, never mid-change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= {mcu_addr, mcu_wdata, mcu_wr_n, mcu_rd_n,
                   primary_sector_select, secondary_sector_select};
      pin_sync <= pin_meta;
    end
  end

  assign {s_addr, s_wdata, s_wr_n, s_rd_n, s_psel, s_ssel} = pin_sync;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
      cap_addr <= '0;
    end else begin
      wr_prev <= s_wr_n;
      rd_prev <= s_rd_n;
      if (wr_fall) begin
        cap_addr <= s_addr;
      end
    end
  end

  assign wr_fall = wr_prev & ~s_wr_n;
  assign wr_rise = ~wr_prev & s_wr_n;
  assign rd_fall = rd_prev & ~s_rd_n;
  assign cmd = s_wdata[7:0];
  assign at_a = cap_addr[11:0] == fcs_pkg::UNLOCK_ADDR_A;
  assign at_b = cap_addr[11:0] == fcs_pkg::UNLOCK_ADDR_B;
  assign pri_sel = |s_psel;
  assign any_sel = pri_sel | (|s_ssel);
  assign sel_bank = ~pri_sel;
  assign sel_mask = pri_sel ? s_psel : {12'h000, s_ssel};
  assign prot_sel = sel_bank ? {12'h000, protect[19:16]} : protect[15:0];
  assign prot_cur = bank ? {12'h000, protect[19:16]} : protect[15:0];
  assign home_st = sus ? ST_SUSP : (byp ? ST_BYP : ST_READ);
  assign seq_st = state inside {ST_UNL1, ST_UNL2, ST_PROG, ST_ES0,
                                ST_ES1, ST_ES2, ST_BPROG};

  // Command decoder and embedded algorithm
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_READ;
      bank <= 1'b0;
      mask <= '0;
      sus <= 1'b0;
      byp <= 1'b0;
      is_erase <= 1'b0;
      is_bulk <= 1'b0;
      pd <= '0;
      tmr <= '0;
      op_cnt <= '0;
      arr_cmd <= '0;
    end else begin
      arr_cmd.prog <= 1'b0;
      arr_cmd.erase <= 1'b0;
      if (tmr != '0) begin
        tmr <= tmr - ONE;
      end
      case (state)
        ST_READ, ST_SUSP, ST_BYP: begin
          if (wr_rise && any_sel) begin
            if (state == ST_BYP && cmd == fcs_pkg::CMD_PROGRAM) begin
              state <= ST_BPROG;
              bank <= sel_bank;
              tmr <= fcs_pkg::CNT_W'(CMD_TIMEOUT_CYC);
            end else if (state == ST_BYP && cmd == fcs_pkg::CMD_IDENT) begin
              state <= ST_BEXIT;
            end else if (state != ST_BYP && at_a &&
                         cmd == fcs_pkg::CMD_UNLOCK_A) begin
              state <= ST_UNL1;
              bank <= sel_bank;
              tmr <= fcs_pkg::CNT_W'(CMD_TIMEOUT_CYC);
            end else if (state == ST_SUSP &&
                         cmd == fcs_pkg::CMD_SECTOR_ERASE) begin
              state <= ST_BUSY;
              sus <= 1'b0;
              is_erase <= 1'b1;
            end
          end
        end
        ST_UNL1: begin
          if (wr_rise) begin
            state <= (at_b && cmd == fcs_pkg::CMD_UNLOCK_B) ?
                     ST_UNL2 : home_st;
            tmr <= fcs_pkg::CNT_W'(CMD_TIMEOUT_CYC);
          end
        end
        ST_UNL2: begin
          if (wr_rise) begin
            tmr <= fcs_pkg::CNT_W'(CMD_TIMEOUT_CYC);
            state <= home_st;
            if (at_a && cmd == fcs_pkg::CMD_IDENT) begin
              state <= ST_ID;
            end else if (at_a && cmd == fcs_pkg::CMD_PROGRAM) begin
              state <= ST_PROG;
            end else if (at_a && !sus &&
                         cmd == fcs_pkg::CMD_ERASE_SETUP) begin
              state <= ST_ES0;
            end else if (at_a && !sus && cmd == fcs_pkg::CMD_BYPASS) begin
              state <= ST_BYP;
              byp <= 1'b1;
            end
          end
        end
        ST_PROG, ST_BPROG: begin
          if (wr_rise) begin
            state <= home_st;
            // Whole word at the captured address; protected or
            // suspended-erase sectors are refused silently
            if (any_sel && (sel_mask & prot_sel) == '0 &&
                !(sus && sel_bank == bank && (sel_mask & mask) != '0)) begin
              pd <= s_wdata;
              arr_cmd.prog <= 1'b1;
              arr_cmd.bank <= sel_bank;
              arr_cmd.addr <= cap_addr;
              arr_cmd.wdata <= s_wdata;
              state <= ST_BUSY;
              is_erase <= 1'b0;
              op_cnt <= fcs_pkg::CNT_W'(fcs_pkg::PROG_CYC);
            end
          end
        end
        ST_ES0, ST_ES1: begin
          if (wr_rise) begin
            tmr <= fcs_pkg::CNT_W'(CMD_TIMEOUT_CYC);
            state <= home_st;
            if (state == ST_ES0 && at_a && cmd == fcs_pkg::CMD_UNLOCK_A) begin
              state <= ST_ES1;
            end else if (state == ST_ES1 && at_b &&
                         cmd == fcs_pkg::CMD_UNLOCK_B) begin
              state <= ST_ES2;
            end
          end
        end
        ST_ES2: begin
          if (wr_rise) begin
            state <= home_st;
            if (any_sel && sel_bank == bank &&
                cmd == fcs_pkg::CMD_SECTOR_ERASE) begin
              mask <= sel_mask;
              is_bulk <= 1'b0;
              state <= ST_EWIN;
              tmr <= fcs_pkg::CNT_W'(ADD_WINDOW_CYC);
            end else if (at_a && cmd == fcs_pkg::CMD_BULK_ERASE) begin
              mask <= bank ? fcs_pkg::ALL_SECONDARY :
                      fcs_pkg::ALL_PRIMARY;
              is_bulk <= 1'b1;
              state <= ST_EWIN;
              tmr <= '0;
            end
          end
        end
        ST_EWIN: begin
          if (wr_rise && !is_bulk) begin
            if (any_sel && sel_bank == bank &&
                cmd == fcs_pkg::CMD_SECTOR_ERASE) begin
              mask <= mask | sel_mask;
              tmr <= fcs_pkg::CNT_W'(ADD_WINDOW_CYC);
            end else begin
              state <= home_st;
            end
          end else if (tmr == '0) begin
            mask <= mask & ~prot_cur;
            if ((mask & ~prot_cur) != '0) begin
              arr_cmd.erase <= 1'b1;
              arr_cmd.bank <= bank;
              arr_cmd.mask <= mask & ~prot_cur;
              state <= ST_BUSY;
              is_erase <= 1'b1;
              op_cnt <= fcs_pkg::CNT_W'(ERASE_CYC);
            end else begin
              state <= home_st;
            end
          end
        end
        ST_BUSY: begin
          if (wr_rise && is_erase && !is_bulk &&
              cmd == fcs_pkg::CMD_SUSPEND) begin
            state <= ST_SUSP;
            sus <= 1'b1;
          end else if (op_cnt <= ONE) begin
            op_cnt <= '0;
            state <= home_st;
          end else begin
            op_cnt <= op_cnt - ONE;
          end
        end
        ST_ID: begin
          if (wr_rise && cmd == fcs_pkg::CMD_RESET) begin
            state <= home_st;
          end
        end
        ST_BEXIT: begin
          if (wr_rise) begin
            state <= ST_BYP;
            if (cmd == fcs_pkg::CMD_BYPASS_EXIT) begin
              state <= ST_READ;
              byp <= 1'b0;
            end
          end
        end
        default: state <= ST_READ;
      endcase
      // An expired gap wins only when no write arrives in that cycle
      if (seq_st && tmr == '0 && !wr_rise) begin
        state <= home_st;
      end
    end
  end

  // Pin follows state one cycle late, straight from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_busy_out <= 1'b1;
    end else begin
      ready_busy_out <= state != ST_BUSY;
    end
  end

  // Read data path: status, identify data or array contents
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog <= 1'b0;
      mcu_rdata <= '0;
    end else begin
      if (state == ST_BUSY && rd_fall) begin
        tog <= ~tog;
      end
      mcu_rdata <= arr_rdata;
      if (state == ST_BUSY) begin
        mcu_rdata <= '0;
        mcu_rdata[fcs_pkg::POLL_BIT] <= is_erase ? 1'b0 : ~pd[7];
        mcu_rdata[fcs_pkg::TOGGLE_BIT] <= tog;
      end else if (state == ST_ID) begin
        mcu_rdata <= '0;
        if (s_addr[7:0] == fcs_pkg::ID_OFFSET && !any_sel) begin
          mcu_rdata[7:0] <= fcs_pkg::PRIMARY_ID;
        end else if (s_addr[7:0] == fcs_pkg::PROT_OFFSET && any_sel) begin
          mcu_rdata[7:0] <= ((sel_mask & prot_sel) != '0) ?
                            fcs_pkg::PROT_YES : fcs_pkg::PROT_NO;
        end
      end else if (state == ST_EWIN) begin
        mcu_rdata <= '0;
        mcu_rdata[fcs_pkg::WINDOW_BIT] <= 1'b1;
      end
    end
  end

  // AXI4-Lite write channel; address and data taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fcs_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      protect <= fcs_pkg::PROTECT_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= fcs_pkg::RESP_OKAY;
        if (aw_addr == fcs_pkg::REG_PROTECT) begin
          if (w_strb[0]) protect[7:0] <= w_data[7:0];
          if (w_strb[1]) protect[15:8] <= w_data[15:8];
          if (w_strb[2]) protect[19:16] <= w_data[19:16];
        end else if (aw_addr != fcs_pkg::REG_STATUS) begin
          s_axi_bresp <= fcs_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= fcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= fcs_pkg::RESP_OKAY;
      if (s_axi_araddr == fcs_pkg::REG_PROTECT) begin
        s_axi_rdata[19:0] <= protect;
      end else if (s_axi_araddr == fcs_pkg::REG_STATUS) begin
        s_axi_rdata[fcs_pkg::STAT_BUSY] <= state == ST_BUSY;
        s_axi_rdata[fcs_pkg::STAT_SUSP] <= sus;
        s_axi_rdata[fcs_pkg::STAT_BYP] <= byp;
        s_axi_rdata[fcs_pkg::STAT_ID] <= state == ST_ID;
        s_axi_rdata[fcs_pkg::STAT_WIN] <= state == ST_EWIN;
      end else begin
        s_axi_rresp <= fcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  chk_busy_pin_low: assert property (
    state == ST_BUSY |=> !ready_busy_out)
    else $error("ready/busy high while busy");
  chk_plain_write_inert: assert property (
    state == ST_READ |=> !arr_cmd.prog && !arr_cmd.erase)
    else $error("array command from read mode");
  chk_prog_protect: assert property (
    arr_cmd.prog |-> $past((sel_mask & prot_sel) == '0))
    else $error("program reached protected sector");
  chk_erase_mask: assert property (
    arr_cmd.erase |-> (arr_cmd.mask & prot_cur) == '0 && arr_cmd.mask != '0)
    else $error("erase mask holds protected or no sector");
  chk_unlock_first: assert property (
    state == ST_UNL1 && $past(state) != ST_UNL1 |->
      $past(wr_rise && at_a && cmd == fcs_pkg::CMD_UNLOCK_A))
    else $error("unlock entered without AAh at AAAh");
  chk_id_sticky: assert property (
    state == ST_ID && !(wr_rise && cmd == fcs_pkg::CMD_RESET) |=>
      state == ST_ID)
    else $error("identify mode left without reset write");
  chk_suspend_cause: assert property (
    state == ST_SUSP && $past(state) == ST_BUSY |->
      $past(is_erase && !is_bulk && wr_rise))
    else $error("suspend outside sector erase");
  chk_gap_timeout: assert property (
    seq_st && tmr == '0 && !wr_rise |=> !seq_st)
    else $error("decoder stuck after time-out");
  chk_toggle_read: assert property (
    state == ST_BUSY && rd_fall |=> tog != $past(tog))
    else $error("toggle bit did not flip on read");
  chk_poll_bit: assert property (
    state == ST_BUSY && !is_erase |=> mcu_rdata[7] == ~$past(pd[7]))
    else $error("polling bit not complement while programming");
  chk_bypass_exit: assert property (
    $fell(byp) |-> $past(state == ST_BEXIT && wr_rise &&
                         cmd == fcs_pkg::CMD_BYPASS_EXIT))
    else $error("bypass left without 90h 00h");
endmodule : fcs_flash_sequencer

// file: design/fcs_pkg.sv
// Purpose: constants and types of the flash command sequencer
// Assumes: 250 MHz system clock, 16-bit MCU bus, AXI4-Lite registers
// Notes: counts above 4096 cycles are top-level parameters
package fcs_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADD_WINDOW_NS = 80000;
  localparam int ADD_WINDOW_CYC = ADD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int CMD_TIMEOUT_CYC = 2048;
  localparam int PROG_CYC = 64;
  localparam int ERASE_CYC = 100000;
  localparam int CNT_W = 24;
  localparam logic [11:0] UNLOCK_ADDR_A = 12'hAAA;
  localparam logic [11:0] UNLOCK_ADDR_B = 12'h554;
  localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  localparam logic [7:0] ID_OFFSET = 8'h02;
  localparam logic [7:0] PROT_OFFSET = 8'h04;
  // Arbitrary value, not a real part code
  localparam logic [7:0] PRIMARY_ID = 8'h5A;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [15:0] ALL_PRIMARY = 16'hFFFF;
  localparam logic [15:0] ALL_SECONDARY = 16'h000F;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int WINDOW_BIT = 3;
  localparam logic [11:0] REG_PROTECT = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [19:0] PROTECT_RESET = 20'h00000;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SUSP = 1;
  localparam int STAT_BYP = 2;
  localparam int STAT_ID = 3;
  localparam int STAT_WIN = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic prog;
    logic erase;
    logic bank;
    logic [15:0] mask;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fcs_arr_cmd_s;
endpackage : fcs_pkg

// file: testbench/fcs_mcu_model.sv
// Purpose: MCU host model driving the flash bus pins
// Assumes: pins change just after a rising clk edge
// Notes: each strobe phase lasts at least 4 clks so the 2-flop sync sees it
`timescale 1ns/1ns
module fcs_mcu_model (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic [15:0] rdata,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic wr_n,
  output logic rd_n
);
  initial begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_n <= 1'b0;
    repeat (6) @(posedge clk);
    wr_n <= 1'b1;
    repeat (6) @(posedge clk);
    // Released data lines show the inverse so stale data never matches
    wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    q = rdata;
    @(posedge clk);
    rd_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rd
endmodule : fcs_mcu_model

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the flash command sequencer
// Assumes: host model drives MCU pins, bench models the arrays
// Notes: long counts shortened by parameters to keep runs short
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk, nrst, aw_val, w_val, b_rdy, ar_val, r_rdy;
  logic aw_rdy, w_rdy, b_val, ar_rdy, r_val, m_wr_n, m_rd_n, rb;
  logic [11:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data, q;
  logic [1:0] b_resp, r_resp, r;
  logic [15:0] psel, m_addr, m_wd, m_rd, s1, s2;
  logic [3:0] ssel;
  logic [15:0] mem [0:15];
  fcs_pkg::fcs_arr_cmd_s acmd;
  int errors, cmp_count, pc, ec, sc;

  fcs_flash_sequencer #(.ADD_WINDOW_CYC(40), .ERASE_CYC(200),
    .CMD_TIMEOUT_CYC(100)) uut (.clk(clk), .nrst(nrst),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_val), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_val),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_val),
    .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_val),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_val), .s_axi_rready(r_rdy), .mcu_addr(m_addr),
    .mcu_wdata(m_wd), .mcu_wr_n(m_wr_n), .mcu_rd_n(m_rd_n),
    .primary_sector_select(psel), .secondary_sector_select(ssel),
    .mcu_rdata(m_rd), .ready_busy_out(rb), .arr_rdata(mem[m_addr[4:1]]),
    .arr_cmd(acmd));
  fcs_mcu_model mcu (.clk(clk), .rdata(m_rd), .addr(m_addr), .wdata(m_wd),
    .wr_n(m_wr_n), .rd_n(m_rd_n));

  // Ideal array: programs overwrite, erase sets every word
  always @(posedge clk) begin
    if (acmd.prog) begin
      mem[acmd.addr[4:1]] <= acmd.wdata;
      pc++;
      if (acmd.bank) sc++;
    end
    if (acmd.erase) begin
      for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
      ec++;
    end
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_val <= 1'b1;
    w_val <= 1'b1;
    b_rdy <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = aw_val && aw_rdy;
      w = w_val && w_rdy;
      b = b_val;
      r = b_resp;
      @(posedge clk);
      if (aw) aw_val <= 1'b0;
      if (w) w_val <= 1'b0;
      if (b) b_rdy <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    logic ar, v;
    @(posedge clk);
    ar_addr <= a;
    ar_val <= 1'b1;
    r_rdy <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge clk);
      ar = ar_val && ar_rdy;
      v = r_val;
      q = r_data;
      r = r_resp;
      @(posedge clk);
      if (ar) ar_val <= 1'b0;
      if (v) r_rdy <= 1'b0;
    end
  endtask : axi_rd

  task automatic unl;
    mcu.wr(16'h0AAA, 16'h00AA);
    mcu.wr(16'h0554, 16'h0055);
  endtask : unl

  task automatic wait_rdy;
    int n;
    n = 0;
    while (rb !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    `CHK("ready", 1'b1, rb)
  endtask : wait_rdy

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #120000;
    errors++;
    print_verdict();
  end

  initial begin
    {nrst, aw_val, w_val, b_rdy, ar_val, r_rdy} = '0;
    {aw_addr, ar_addr, w_data} = '0;
    psel = 16'h0001;
    ssel = 4'h0;
    for (int i = 0; i < 16; i++) mem[i] = {12'hC3C, i[3:0]};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("status", 32'h0, q)
    `CHK("rresp", fcs_pkg::RESP_OKAY, r)
    `CHK("rdy", 1'b1, rb)
    mcu.wr(16'h0004, 16'h1234);
    mcu.rd(16'h0004, s1);
    `CHK("plain", 16'hC3C2, s1)
    $display("test read done");
    unl();
    mcu.wr(16'hFAAA, 16'h00A0);
    mcu.wr(16'hF004, 16'h1234);
    mcu.rd(16'hF004, s1);
    `CHK("busy", 1'b0, rb)
    mcu.rd(16'hF004, s2);
    `CHK("poll", 7'h40, {s1[7], s1[5:0]})
    `CHK("toggle", 1'b1, s1[6] ^ s2[6])
    wait_rdy();
    mcu.rd(16'h0004, s1);
    `CHK("prog", 16'h1234, s1)
    $display("test program done");
    unl();
    mcu.wr(16'h0AAA, 16'h0020);
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("byp", 1'b1, q[fcs_pkg::STAT_BYP])
    mcu.wr(16'h0000, 16'h00A0);
    mcu.wr(16'h0006, 16'h5678);
    wait_rdy();
    mcu.wr(16'h0000, 16'h0090);
    mcu.wr(16'h0000, 16'h0000);
    mcu.rd(16'h0006, s1);
    `CHK("bypprog", 16'h5678, s1)
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("bypexit", 1'b0, q[fcs_pkg::STAT_BYP])
    $display("test bypass done");
    unl();
    repeat (120) @(posedge clk);
    mcu.wr(16'h0AAA, 16'h00A0);
    mcu.wr(16'h0008, 16'hAAAA);
    `CHK("tmo", 2, pc)
    axi_wr(fcs_pkg::REG_PROTECT, 32'h1);
    axi_rd(fcs_pkg::REG_PROTECT);
    `CHK("prot", 32'h1, q)
    axi_wr(12'h008, 32'h1);
    `CHK("slverr", fcs_pkg::RESP_SLVERR, r)
    unl();
    mcu.wr(16'h0AAA, 16'h00A0);
    mcu.wr(16'h0002, 16'h0000);
    repeat (10) @(posedge clk);
    `CHK("protprog", 2, pc)
    unl();
    mcu.wr(16'h0AAA, 16'h0090);
    mcu.rd(16'h0004, s1);
    `CHK("protstat", fcs_pkg::PROT_YES, s1[7:0])
    psel <= 16'h0000;
    mcu.rd(16'h0002, s1);
    mcu.rd(16'h0002, s2);
    `CHK("ident", {2{fcs_pkg::PRIMARY_ID}}, {s1[7:0], s2[7:0]})
    psel <= 16'h0001;
    mcu.wr(16'h0000, 16'h00F0);
    mcu.rd(16'h0002, s1);
    `CHK("f0", 16'hC3C1, s1)
    $display("test protect done");
    axi_wr(fcs_pkg::REG_PROTECT, 32'h0);
    mcu.wr(16'h0000, 16'h00B0);
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("nosusp", 32'h0, q)
    unl();
    mcu.wr(16'h0AAA, 16'h0080);
    unl();
    mcu.wr(16'h0000, 16'h0030);
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("window", 1'b1, q[fcs_pkg::STAT_WIN])
    repeat (40) @(posedge clk);
    mcu.wr(16'h0000, 16'h00B0);
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("susp", 1'b1, q[fcs_pkg::STAT_SUSP])
    mcu.wr(16'h0000, 16'h0030);
    axi_rd(fcs_pkg::REG_STATUS);
    `CHK("resume", 1'b0, q[fcs_pkg::STAT_SUSP])
    wait_rdy();
    mcu.rd(16'h0004, s1);
    `CHK("erase", 16'hFFFF, s1)
    `CHK("ecount", 1, ec)
    $display("test erase done");
    psel <= 16'h0000;
    ssel <= 4'h1;
    unl();
    mcu.wr(16'h0AAA, 16'h00A0);
    mcu.wr(16'h000A, 16'h0BEE);
    wait_rdy();
    mcu.rd(16'h000A, s1);
    `CHK("secprog", 16'h0BEE, s1)
    `CHK("secbank", 1, sc)
    unl();
    mcu.wr(16'h0AAA, 16'h0080);
    unl();
    mcu.wr(16'h0AAA, 16'h0010);
    wait_rdy();
    mcu.rd(16'h000A, s1);
    `CHK("bulk", 16'hFFFF, s1)
    `CHK("bcount", 2, ec)
    $display("test bulk done");
    print_verdict();
  end
endmodule : tb_top
